//--- rtl/strap_pkg.sv
// Purpose: Constants and types for the reset, strap and host port block
// Assumes: 40 MHz mclk, all pin inputs synchronous to mclk
// Notes: Overview of operation follows
// Overview of operation
// - Power-on reset pin low resets the device
// - Registers usable after 55 ms or ready bit
// - Pin 3 strap picks I2C or SPI
// - Pins 1 and 0 pick master clock rate
// - Processor owns general pins after strap period; code drives the irq_pin_sel pin from host_irq when irq_pin_en is set
// - Interrupt pin flags device status changes
// - Host drives shared serial clock pin
// - Serial input pin carries command, address, data
// - SPI read data out, else address select
// - Chip select frames SPI, else address select
package strap_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int STRAP_WAIT_MS = 55;
	localparam int STRAP_CYCLES = (CLK_HZ / 1000) * STRAP_WAIT_MS;
	localparam int CNT_W = 22;

	// ==========================================================
	// Register map
	localparam logic [7:0] REG_READY_ADDR = 8'h00;
	localparam int READY_BIT = 7;
	localparam logic [7:0] REG_READ_ZERO = 8'h00;

	// ==========================================================
	// Pin layout
	localparam int GPIO_N = 12;
	localparam int STRAP_MODE_PIN = 3;
	localparam int STRAP_RATE_LO = 0;
	localparam int STRAP_RATE_HI = 1;
	localparam int STATUS_W = 8;
	localparam logic [GPIO_N-1:0] GPIO_OFF = 12'h000;
	localparam logic [3:0] IRQ_PIN_RESET = 4'h0;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_STRAP = 3'b010,
		ST_RUN = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic i2c_mode;
		logic [1:0] clk_rate;
	} strap_t;

	localparam strap_t STRAP_RESET = 3'h0;

endpackage

//--- rtl/reset_strap_host_port_select.sv
// Purpose: Power-on reset sequencing, strap capture, host pin routing
// Assumes: Serial protocol engine sits outside and uses the routed pins
// Notes: Pins other than an enabled interrupt pin released to processor when the strap window closes
`timescale 1ns/1ps
module reset_strap_host_port_select
	import strap_pkg::*;
#(
	parameter int STRAP_WAIT = STRAP_CYCLES
)
(
	input wire logic mclk, // 40 MHz clock
	input wire logic srst, // Sync reset, active high
	input wire logic ce, // Clock enable
	input wire logic pwr_n, // Power-on reset pin, active low
	input wire logic [GPIO_N-1:0] gpio_in, // General pin levels
	output logic [GPIO_N-1:0] gpio_out, // General pin drive values
	output logic [GPIO_N-1:0] gpio_oe, // General pin drive enables
	input wire logic [GPIO_N-1:0] proc_gpio_out, // Processor pin values
	input wire logic [GPIO_N-1:0] proc_gpio_oe, // Processor pin enables
	input wire logic irq_pin_en, // Interrupt output enabled
	input wire logic [3:0] irq_pin_sel, // Pin used as interrupt
	input wire logic [STATUS_W-1:0] dev_status, // Device status vector
	input wire logic isr_clear, // Service registers read
	input wire logic sck_scl_in, // Shared serial clock pin
	input wire logic si_sda_in, // Serial input or I2C data pin
	output logic si_sda_out, // I2C data drive value
	output logic si_sda_oe, // I2C data drive enable
	input wire logic host_serial_out_addr_sel_hi_in, // Out pin level
	output logic host_serial_out_addr_sel_hi_out, // SPI read bit
	output logic host_serial_out_addr_sel_hi_oe, // SPI read enable
	input wire logic host_select_n_addr_sel_lo, // Chip select pin
	input wire logic eng_sda_low, // Engine pulls data line low
	input wire logic eng_tx_bit, // Engine read data bit
	output logic eng_sck, // Serial clock to engine
	output logic eng_sdi, // Serial data to engine
	output logic eng_select, // SPI frame active
	output logic [1:0] i2c_addr_sel, // I2C address select bits
	input wire logic reg_rd, // Register read strobe
	input wire logic [7:0] reg_addr, // Register address
	output logic [7:0] reg_rdata, // Register read data
	output strap_t strap, // Latched strap settings
	output logic dev_ready, // Registers accessible
	output logic dev_reset, // Device held in reset
	output logic host_irq // Interrupt level
);

	// ==========================================================
	// Sequencer
	seq_state_t state;
	logic [CNT_W-1:0] cnt;
	logic strap_end;
	logic [STATUS_W-1:0] prev_status;
	logic status_change;
	logic host_live;

	assign strap_end = (cnt == CNT_W'(STRAP_WAIT - 1));
	assign status_change = (dev_status != prev_status);
	// Host pin drives drop on the same edge as ready when reset pin falls
	assign host_live = dev_ready && pwr_n;

	always_ff @(posedge mclk)
	begin
		if (srst)
			state <= ST_RESET;
		else if (ce)
		begin
			if (!pwr_n)
				state <= ST_RESET;
			else
			begin
				unique case (state)
					ST_RESET: state <= ST_STRAP;
					ST_STRAP:
					begin
						if (strap_end)
							state <= ST_RUN;
					end
					ST_RUN: state <= ST_RUN;
					default: state <= ST_RESET;
				endcase
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			cnt <= '0;
		else if (ce)
		begin
			if (state != ST_STRAP || !pwr_n)
				cnt <= '0;
			else if (!strap_end)
				cnt <= cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			dev_ready <= 1'b0;
			dev_reset <= 1'b1;
		end
		else if (ce)
		begin
			dev_ready <= pwr_n && (state == ST_RUN ||
				(state == ST_STRAP && strap_end));
			dev_reset <= !pwr_n || state == ST_RESET;
		end
	end

	// ==========================================================
	// Strap capture at close of strap window
	always_ff @(posedge mclk)
	begin
		if (srst)
			strap <= STRAP_RESET;
		else if (ce && pwr_n && state == ST_STRAP && strap_end)
		begin
			strap.i2c_mode <= gpio_in[STRAP_MODE_PIN];
			strap.clk_rate <= {gpio_in[STRAP_RATE_HI],
				gpio_in[STRAP_RATE_LO]};
		end
	end

	// ==========================================================
	// Status change interrupt, set wins over clear
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			prev_status <= '0;
			host_irq <= 1'b0;
		end
		else if (ce)
		begin
			prev_status <= dev_status;
			if (state != ST_RUN || !pwr_n)
				host_irq <= 1'b0;
			else if (status_change)
				host_irq <= 1'b1;
			else if (isr_clear)
				host_irq <= 1'b0;
		end
	end

	// ==========================================================
	// General pins: quiet during straps, then processor owned except an enabled interrupt pin
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			gpio_out <= GPIO_OFF;
			gpio_oe <= GPIO_OFF;
		end
		else if (ce)
		begin
			if (state == ST_RUN && pwr_n)
			begin
				for (int i = 0; i < GPIO_N; i++)
				begin
					if (irq_pin_en && irq_pin_sel == 4'(i))
					begin
						gpio_out[i] <= host_irq;
						gpio_oe[i] <= 1'b1;
					end
					else
					begin
						gpio_out[i] <= proc_gpio_out[i];
						gpio_oe[i] <= proc_gpio_oe[i];
					end
				end
			end
			else
			begin
				gpio_out <= GPIO_OFF;
				gpio_oe <= GPIO_OFF;
			end
		end
	end

	// ==========================================================
	// Host serial pin routing by strap mode
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			eng_sck <= 1'b0;
			eng_sdi <= 1'b0;
			eng_select <= 1'b0;
			i2c_addr_sel <= 2'h0;
			si_sda_out <= 1'b0;
			si_sda_oe <= 1'b0;
			host_serial_out_addr_sel_hi_out <= 1'b0;
			host_serial_out_addr_sel_hi_oe <= 1'b0;
		end
		else if (ce)
		begin
			eng_sck <= sck_scl_in;
			eng_sdi <= si_sda_in;
			eng_select <= host_live && !strap.i2c_mode &&
				!host_select_n_addr_sel_lo;
			i2c_addr_sel <= strap.i2c_mode ?
				{host_serial_out_addr_sel_hi_in,
				host_select_n_addr_sel_lo} : 2'h0;
			si_sda_out <= 1'b0;
			si_sda_oe <= host_live && strap.i2c_mode &&
				eng_sda_low;
			host_serial_out_addr_sel_hi_out <= eng_tx_bit;
			host_serial_out_addr_sel_hi_oe <= host_live &&
				!strap.i2c_mode && !host_select_n_addr_sel_lo;
		end
	end

	// ==========================================================
	// Ready status register
	always_ff @(posedge mclk)
	begin
		if (srst)
			reg_rdata <= REG_READ_ZERO;
		else if (ce && reg_rd)
		begin
			reg_rdata <= REG_READ_ZERO;
			if (reg_addr == REG_READY_ADDR)
				reg_rdata[READY_BIT] <= dev_ready;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	chk_reset_enter: assert property (ce && !pwr_n |=>
		state == ST_RESET ##0 !dev_ready ##0 dev_reset)
		else $error("reset pin low did not reset device");
	chk_ready_time: assert property (
		ce && pwr_n && state == ST_STRAP && strap_end |=> dev_ready)
		else $error("ready bit not set at strap window end");
	chk_ready_early: assert property (
		state == ST_STRAP && !strap_end |=> !dev_ready)
		else $error("ready bit set before strap window end");
	chk_mode_latch: assert property (
		ce && pwr_n && state == ST_STRAP && strap_end |=>
		strap.i2c_mode == $past(gpio_in[STRAP_MODE_PIN]))
		else $error("host mode strap not captured");
	chk_rate_latch: assert property (
		ce && pwr_n && state == ST_STRAP && strap_end |=>
		strap.clk_rate == $past(gpio_in[1:0]))
		else $error("clock rate strap not captured");
	chk_strap_hold: assert property (
		state == ST_RUN && $past(state) == ST_RUN |-> $stable(strap))
		else $error("strap changed after capture");
	chk_gpio_quiet: assert property (
		state != ST_RUN |=> gpio_oe == GPIO_OFF)
		else $error("general pin driven in strap window");
	chk_irq_set: assert property (
		ce && pwr_n && state == ST_RUN && status_change |=> host_irq)
		else $error("status change did not raise interrupt");
	chk_spi_out: assert property (
		host_serial_out_addr_sel_hi_oe |-> !strap.i2c_mode && dev_ready)
		else $error("serial out driven outside SPI mode");
	chk_ready_read: assert property (
		ce && reg_rd && reg_addr == REG_READY_ADDR |=>
		reg_rdata[READY_BIT] == $past(dev_ready) &&
		reg_rdata[6:0] == 7'h00)
		else $error("ready register read wrong");

	cov_run: cover property (state == ST_STRAP ##1 state == ST_RUN);
	cov_i2c: cover property (dev_ready && strap.i2c_mode);
	cov_irq: cover property (host_irq ##1 !host_irq);
	cov_reset_run: cover property (state == ST_RUN ##1 state == ST_RESET);

endmodule

//--- tb/strap_host_model.sv
// Purpose: Board and host side of power-on reset and strap pins
// Assumes: Driven on falling mclk edges
// Notes: Released strap pins fall to their pull-down level
`timescale 1ns/1ps
module strap_host_model
	import strap_pkg::*;
#(
	parameter int HOLD = 5,
	parameter int STRAP_HOLD = 23
)
(
	input wire logic mclk, // Clock
	input wire logic por_go, // Start a power-on reset
	input wire logic [2:0] strap_val, // Mode, rate high, rate low
	output logic pwr_n, // Power-on reset pin
	output logic [GPIO_N-1:0] gpio_in // General pin levels
);
	int cnt = 0;
	// ==========================================================
	// Reset pulse and strap drive
	always @(negedge mclk)
	begin
		cnt <= por_go ? 0 : (cnt < 1000 ? cnt + 1 : cnt);
		pwr_n <= !por_go && cnt >= HOLD;
		if (cnt < HOLD + STRAP_HOLD)
			gpio_in <= {8'hFC, strap_val[2], 1'b0, strap_val[1:0]};
		else
			gpio_in <= 12'hFC0;
	end
endmodule

//--- tb/reset_strap_host_port_select_tb.sv
// Purpose: Self-checking bench for reset, strap and host pin routing
// Assumes: Shortened strap window
// Notes: Inputs change on falling mclk edges
`timescale 1ns/1ps
module reset_strap_host_port_select_tb;
	import strap_pkg::*;
	localparam int SW = 20;
	logic mclk = 0, srst = 1, ce = 1, por_go = 0, pwr_n;
	logic [2:0] strap_val = 3'h0;
	logic [GPIO_N-1:0] gpio_in, gpio_out, gpio_oe;
	logic [GPIO_N-1:0] proc_gpio_out = 12'h000, proc_gpio_oe = 12'h000;
	logic irq_pin_en = 0, isr_clear = 0, reg_rd = 0, eng_sda_low = 0;
	logic [3:0] irq_pin_sel = 4'h0;
	logic [7:0] dev_status = 8'h00, reg_addr = 8'h00, reg_rdata;
	logic sck_scl_in = 0, si_sda_in = 0, eng_tx_bit = 0;
	logic host_serial_out_addr_sel_hi_in = 0;
	logic host_select_n_addr_sel_lo = 1;
	logic si_sda_out, si_sda_oe, so_out, so_oe, eng_sck, eng_sdi;
	logic eng_select, dev_ready, dev_reset, host_irq;
	logic [1:0] i2c_addr_sel;
	strap_t strap;
	int miscompares = 0, tests_run = 0;
	always #12.5 mclk = !mclk;
	strap_host_model #(.HOLD(5), .STRAP_HOLD(SW + 3)) u_strap_host_model (
		.mclk, .por_go, .strap_val, .pwr_n, .gpio_in);
	reset_strap_host_port_select #(.STRAP_WAIT(SW))
		u_reset_strap_host_port_select (
		.mclk, .srst, .ce, .pwr_n, .gpio_in, .gpio_out, .gpio_oe,
		.proc_gpio_out, .proc_gpio_oe, .irq_pin_en, .irq_pin_sel,
		.dev_status, .isr_clear, .sck_scl_in, .si_sda_in, .si_sda_out,
		.si_sda_oe, .host_serial_out_addr_sel_hi_in,
		.host_serial_out_addr_sel_hi_out(so_out),
		.host_serial_out_addr_sel_hi_oe(so_oe),
		.host_select_n_addr_sel_lo, .eng_sda_low, .eng_tx_bit, .eng_sck,
		.eng_sdi, .eng_select, .i2c_addr_sel, .reg_rd, .reg_addr,
		.reg_rdata, .strap, .dev_ready, .dev_reset, .host_irq);
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd = 1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 0;
		check(reg_rdata, exp);
		@(negedge mclk);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic power_up(input logic [2:0] sv);
		int n;
		strap_val <= sv;
		por_go <= 1'b1;
		wait_n(1);
		por_go <= 1'b0;
		wait_n(2);
		check({dev_reset, dev_ready, gpio_oe}, 14'h2000);
		for (n = 0; n < 20 && pwr_n !== 1'b1; n++) wait_n(1);
		for (n = 0; n < 200 && dev_ready !== 1'b1; n++) wait_n(1);
		check(n >= SW && n <= SW + 2, 1);
		check(strap, sv);
		check(dev_reset, 0);
		wait_n(SW);
		check(strap, sv);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		wait_n(10);
		srst = 0;
		rd(8'h00, 8'h00);
		power_up(3'b010);
		rd(8'h00, 8'h80);
		rd(8'h5A, 8'h00);
		proc_gpio_out = 12'hA5C;
		proc_gpio_oe = 12'h3F0;
		host_select_n_addr_sel_lo = 0;
		{eng_tx_bit, sck_scl_in, si_sda_in, eng_sda_low} = 4'hF;
		host_serial_out_addr_sel_hi_in = 1;
		wait_n(2);
		check({gpio_out, gpio_oe}, 24'hA5C3F0);
		check({eng_select, so_oe, so_out, si_sda_oe,
			i2c_addr_sel}, 6'h38);
		check({eng_sck, eng_sdi}, 2'h3);
		{host_select_n_addr_sel_lo, sck_scl_in, si_sda_in} = 3'h4;
		eng_tx_bit = 0;
		wait_n(2);
		check({eng_select, so_oe, so_out, eng_sck,
			eng_sdi}, 5'h00);
		// Frozen clock enable holds off the interrupt
		ce = 0;
		irq_pin_en = 1;
		irq_pin_sel = 4'h1;
		dev_status = 8'h01;
		wait_n(2);
		check({host_irq, gpio_oe[1]}, 2'h0);
		ce = 1;
		wait_n(3);
		check({host_irq, gpio_out[1], gpio_oe[1]}, 3'h7);
		// Change in the clearing cycle keeps the flag set
		dev_status = 8'h03;
		isr_clear = 1;
		wait_n(1);
		check(host_irq, 1);
		wait_n(1);
		isr_clear = 0;
		wait_n(2);
		check({host_irq, gpio_out[1]}, 2'h0);
		power_up(3'b111);
		host_select_n_addr_sel_lo = 0;
		wait_n(2);
		check({i2c_addr_sel, si_sda_oe, si_sda_out, eng_select,
			so_oe}, 6'h28);
		{host_select_n_addr_sel_lo, host_serial_out_addr_sel_hi_in} = 2'h2;
		eng_sda_low = 0;
		wait_n(2);
		check({i2c_addr_sel, si_sda_oe}, 3'h2);
		complete_run();
	end
	// Watchdog against a hung wait
	initial
	begin
		wait_n(4000);
		miscompares++;
		complete_run();
	end
endmodule
